/* pkg/pad_port_pkg.sv */
// Purpose: shared constants for the pad port block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package pad_port_pkg;
    localparam int PAD_W = 4;
    localparam int ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] OFS_DRIVE_AB = 8'h00;
    localparam logic [7:0] OFS_DIR_A = 8'h04;
    localparam logic [7:0] OFS_DIR_B = 8'h08;
    localparam logic [7:0] OFS_PULL_CDEF = 8'h0C;
    localparam logic [7:0] OFS_TONE_CTL = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN_C = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN_D = 8'h18;
    localparam logic [7:0] OFS_DATA_A = 8'h1C;
    localparam logic [7:0] OFS_DATA_B = 8'h20;
    localparam logic [7:0] OFS_DATA_E = 8'h24;
    localparam logic [7:0] OFS_DATA_F = 8'h28;
    localparam logic [7:0] OFS_PIN_LVL = 8'h2C;
    localparam logic [7:0] OFS_IRQ_PEND = 8'h30;
    // field positions
    localparam int BIT_OD_A = 0;
    localparam int BIT_OD_B = 1;
    localparam int BIT_OD_E = 0;
    localparam int BIT_OD_F = 1;
    localparam int BIT_PULL_C = 2;
    localparam int BIT_PULL_D = 3;
    localparam int BIT_TONE_EN = 0;
    localparam int BIT_TONE_PAD = 3;
    localparam int BIT_SER_CLK = 1;
    localparam int BIT_SER_DATA = 2;
    localparam int BIT_SER_ADDR = 3;
    localparam int POS_PEND_A = 0;
    localparam int POS_PEND_C = 4;
    localparam int POS_PEND_D = 8;
    localparam int POS_LVL_B = 4;
    localparam int POS_LVL_C = 8;
    localparam int POS_LVL_D = 12;
    // reset values
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [11:0] RST_PEND = 12'h000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : pad_port_pkg

/* pkg/pin_sync_if.sv */
// Purpose: carries raw pad levels into the synchroniser and clean levels back
// Assumes: one clock domain on the consumer side
// Notes: width is the count of input pads
`timescale 1ns/100ps
interface pin_sync_if #(parameter int W = 16);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync_end (input raw, output clean);
    modport user_end (output raw, input clean);
endinterface : pin_sync_if

/* src/pin_sync.sv */
// Purpose: two-stage synchroniser for every input pad
// Assumes: pads are asynchronous to pclk
// Notes: the first stage feeds only the second stage
`timescale 1ns/100ps
module pin_sync
    import pad_port_pkg::*;
#(
    parameter int W = 16
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    pin_sync_if.sync_end pins
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    // hold both stages while the clock enable is low
    always_comb
    begin
        nxt_meta = clk_en ? pins.raw : meta_ff;
        nxt_sync = clk_en ? meta_ff : sync_ff;
    end

    // reset to all zero; a pad held high still shows a rising edge once real samples arrive
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign pins.clean = sync_ff; // see R17

    a_sync_two_stage: assert property ( // see R17
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) && $past(clk_en) && clk_en ##1 clk_en |-> sync_ff == $past(pins.raw, 2))
        else $error("synchroniser output is not the input two cycles back");
endmodule : pin_sync

/* src/pad_port_control.sv */
// Purpose: pad ports a..f with direction, drive type, pull-high, pad irq and wake
// Assumes: apb slave on pclk; speech and melody units drive their signals on pclk
// Notes: pad outputs come from flops, so pins change one cycle after a write
// Function
// R1: port a pad direction from dir_mask_a
// R2: drive_type_select_ab bit 0 picks port a drive
// R3: ports a and b come up as inputs
// R4: tone enable puts tone on pad a3
// R5: port a inputs raise an interrupt request
// R6: port b direction and drive type selected
// R7: port c schmitt inputs, pull-high by bit 2
// R8: port c pads each gated by edge_irq_en_low
// R9: activity on ports c or d wakes stop mode
// R10: pad c0 also feeds timer event counter
// R11: port d schmitt inputs, pull-high by bit 3
// R12: port d pads each gated by edge_irq_en_high
// R13: shared-bus option maps serial lines to d1..d3
// R14: tri-state option floats serial lines when idle
// R15: port e output-only, drive by bit 0
// R16: port f output-only, drive by bit 1
// R17: input pads pass two flops before use
// R18: pad change latches request until software clears
`timescale 1ns/100ps
module pad_port_control
    import pad_port_pkg::*;
#(
    parameter bit SHARED_SERIAL = 1'b0,
    parameter bit TRISTATE_SERIAL = 1'b0
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PAD_W-1:0] port_a_pins_i,
    output logic [PAD_W-1:0] port_a_pins_o,
    output logic [PAD_W-1:0] port_a_pins_oe,
    input wire logic [PAD_W-1:0] port_b_pins_i,
    output logic [PAD_W-1:0] port_b_pins_o,
    output logic [PAD_W-1:0] port_b_pins_oe,
    input wire logic [PAD_W-1:0] wake_input_port_c,
    output logic pull_en_c,
    input wire logic [PAD_W-1:0] wake_input_port_d_i,
    output logic [PAD_W-1:0] wake_input_port_d_o,
    output logic [PAD_W-1:0] wake_input_port_d_oe,
    output logic pull_en_d,
    output logic [PAD_W-1:0] port_e_out_o,
    output logic [PAD_W-1:0] port_e_out_oe,
    output logic [PAD_W-1:0] port_f_out_o,
    output logic [PAD_W-1:0] port_f_out_oe,
    input wire logic tone_in,
    input wire logic voice_active,
    input wire logic ser_clk,
    input wire logic ser_addr,
    input wire logic ser_data_out,
    input wire logic ser_data_drive,
    output logic ser_data_in,
    input wire logic stop_mode,
    output logic wake_req,
    output logic timer_event_in,
    output logic irq_port_a,
    output logic irq_port_c,
    output logic irq_port_d
);
    localparam int SW = 4 * PAD_W;
    localparam logic [1:0] WARM_DONE = 2'h3; // sync and prev both hold real pad samples

    // pads driven as {oe, o}; open drain only ever pulls low
    function automatic logic [2*PAD_W-1:0] drive_pads(
        input logic [PAD_W-1:0] data,
        input logic [PAD_W-1:0] en,
        input logic open_drain
    );
        logic [PAD_W-1:0] o;
        logic [PAD_W-1:0] oe;
        o = open_drain ? '0 : data;
        oe = open_drain ? (en & ~data) : en;
        return {oe, o};
    endfunction : drive_pads

    pin_sync_if #(.W(SW)) sync_bus ();

    assign sync_bus.raw = {wake_input_port_d_i, wake_input_port_c, port_b_pins_i, port_a_pins_i};

    pin_sync #(.W(SW)) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .pins(sync_bus.sync_end)
    );

    logic [PAD_W-1:0] lvl_a;
    logic [PAD_W-1:0] lvl_b;
    logic [PAD_W-1:0] lvl_c;
    logic [PAD_W-1:0] lvl_d;
    assign {lvl_d, lvl_c, lvl_b, lvl_a} = sync_bus.clean; // see R17

    // software registers
    logic [PAD_W-1:0] drive_type_select_ab_ff, nxt_drive_type_select_ab;
    logic [PAD_W-1:0] dir_mask_a_ff, nxt_dir_mask_a;
    logic [PAD_W-1:0] dir_mask_b_ff, nxt_dir_mask_b;
    logic [PAD_W-1:0] pull_and_drive_cd_ef_ff, nxt_pull_and_drive_cd_ef;
    logic [PAD_W-1:0] tone_pin_enable_ctl_ff, nxt_tone_pin_enable_ctl;
    logic [PAD_W-1:0] edge_irq_en_low_ff, nxt_edge_irq_en_low;
    logic [PAD_W-1:0] edge_irq_en_high_ff, nxt_edge_irq_en_high;
    logic [PAD_W-1:0] data_a_ff, nxt_data_a;
    logic [PAD_W-1:0] data_b_ff, nxt_data_b;
    logic [PAD_W-1:0] data_e_ff, nxt_data_e;
    logic [PAD_W-1:0] data_f_ff, nxt_data_f;
    logic [3*PAD_W-1:0] pend_ff, nxt_pend;
    logic [SW-1:0] prev_ff, nxt_prev;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;

    logic wr_en;
    logic [3*PAD_W-1:0] pend_set;
    logic [3*PAD_W-1:0] pend_clr;
    logic [PAD_W-1:0] chg_a;
    logic [PAD_W-1:0] chg_c;
    logic [PAD_W-1:0] chg_d;
    logic mapped;
    logic [1:0] warm_ff, nxt_warm;
    logic armed;

    // edges are ignored until prev holds a real sample, else reset zeros look like a change
    assign armed = (warm_ff == WARM_DONE);

    // apb: answer in the cycle after setup, write commits on the access edge
    assign wr_en = psel & penable & pready_ff & pwrite;

    always_comb
    begin
        unique case (paddr)
            OFS_DRIVE_AB, OFS_DIR_A, OFS_DIR_B, OFS_PULL_CDEF, OFS_TONE_CTL,
            OFS_IRQ_EN_C, OFS_IRQ_EN_D, OFS_DATA_A, OFS_DATA_B, OFS_DATA_E,
            OFS_DATA_F, OFS_PIN_LVL, OFS_IRQ_PEND: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // register writes and read data capture
    always_comb
    begin
        nxt_drive_type_select_ab = drive_type_select_ab_ff;
        nxt_dir_mask_a = dir_mask_a_ff;
        nxt_dir_mask_b = dir_mask_b_ff;
        nxt_pull_and_drive_cd_ef = pull_and_drive_cd_ef_ff;
        nxt_tone_pin_enable_ctl = tone_pin_enable_ctl_ff;
        nxt_edge_irq_en_low = edge_irq_en_low_ff;
        nxt_edge_irq_en_high = edge_irq_en_high_ff;
        nxt_data_a = data_a_ff;
        nxt_data_b = data_b_ff;
        nxt_data_e = data_e_ff;
        nxt_data_f = data_f_ff;
        pend_clr = '0;
        nxt_pready = psel & ~penable;
        nxt_pslverr = psel & ~penable & ~mapped;
        nxt_prdata = prdata_ff;
        if (wr_en)
        begin
            unique case (paddr)
                OFS_DRIVE_AB: nxt_drive_type_select_ab = pwdata[PAD_W-1:0]; // see R2
                OFS_DIR_A: nxt_dir_mask_a = pwdata[PAD_W-1:0]; // see R1
                OFS_DIR_B: nxt_dir_mask_b = pwdata[PAD_W-1:0]; // see R6
                OFS_PULL_CDEF: nxt_pull_and_drive_cd_ef = pwdata[PAD_W-1:0];
                OFS_TONE_CTL: nxt_tone_pin_enable_ctl = pwdata[PAD_W-1:0];
                OFS_IRQ_EN_C: nxt_edge_irq_en_low = pwdata[PAD_W-1:0]; // see R8
                OFS_IRQ_EN_D: nxt_edge_irq_en_high = pwdata[PAD_W-1:0]; // see R12
                OFS_DATA_A: nxt_data_a = pwdata[PAD_W-1:0];
                OFS_DATA_B: nxt_data_b = pwdata[PAD_W-1:0];
                OFS_DATA_E: nxt_data_e = pwdata[PAD_W-1:0];
                OFS_DATA_F: nxt_data_f = pwdata[PAD_W-1:0];
                OFS_IRQ_PEND: pend_clr = pwdata[3*PAD_W-1:0]; // write one to clear
                default: nxt_data_a = data_a_ff;
            endcase
        end
        if (psel & ~penable)
        begin
            unique case (paddr)
                OFS_DRIVE_AB: nxt_prdata = {28'h000_0000, drive_type_select_ab_ff};
                OFS_DIR_A: nxt_prdata = {28'h000_0000, dir_mask_a_ff};
                OFS_DIR_B: nxt_prdata = {28'h000_0000, dir_mask_b_ff};
                OFS_PULL_CDEF: nxt_prdata = {28'h000_0000, pull_and_drive_cd_ef_ff};
                OFS_TONE_CTL: nxt_prdata = {28'h000_0000, tone_pin_enable_ctl_ff};
                OFS_IRQ_EN_C: nxt_prdata = {28'h000_0000, edge_irq_en_low_ff};
                OFS_IRQ_EN_D: nxt_prdata = {28'h000_0000, edge_irq_en_high_ff};
                OFS_DATA_A: nxt_prdata = {28'h000_0000, data_a_ff};
                OFS_DATA_B: nxt_prdata = {28'h000_0000, data_b_ff};
                OFS_DATA_E: nxt_prdata = {28'h000_0000, data_e_ff};
                OFS_DATA_F: nxt_prdata = {28'h000_0000, data_f_ff};
                OFS_PIN_LVL: nxt_prdata = {16'h0000, sync_bus.clean};
                OFS_IRQ_PEND: nxt_prdata = {20'h0_0000, pend_ff};
                default: nxt_prdata = RST_WORD;
            endcase
        end
    end

    // pad change detection; port a counts only pads in input mode
    always_comb
    begin
        nxt_prev = sync_bus.clean;
        nxt_warm = armed ? warm_ff : warm_ff + 2'h1;
        chg_a = (lvl_a ^ prev_ff[POS_PEND_A +: PAD_W]) & ~dir_mask_a_ff; // see R5
        chg_c = (lvl_c ^ prev_ff[POS_LVL_C +: PAD_W]) & edge_irq_en_low_ff; // see R8
        chg_d = (lvl_d ^ prev_ff[POS_LVL_D +: PAD_W]) & edge_irq_en_high_ff; // see R12
        pend_set = {chg_d, chg_c, chg_a} & {3*PAD_W{armed}};
        nxt_pend = (pend_ff & ~pend_clr) | pend_set; // see R18
    end

    // pad drive values, all registered so the pins never glitch
    logic [PAD_W-1:0] a_o_ff, nxt_a_o, a_oe_ff, nxt_a_oe;
    logic [PAD_W-1:0] b_o_ff, nxt_b_o, b_oe_ff, nxt_b_oe;
    logic [PAD_W-1:0] d_o_ff, nxt_d_o, d_oe_ff, nxt_d_oe;
    logic [PAD_W-1:0] e_o_ff, nxt_e_o, e_oe_ff, nxt_e_oe;
    logic [PAD_W-1:0] f_o_ff, nxt_f_o, f_oe_ff, nxt_f_oe;
    logic pull_c_ff, nxt_pull_c, pull_d_ff, nxt_pull_d;
    logic wake_ff, nxt_wake, event_ff, nxt_event, ser_in_ff, nxt_ser_in;
    logic ser_drive;

    always_comb
    begin
        {nxt_a_oe, nxt_a_o} = drive_pads(data_a_ff, dir_mask_a_ff,
            drive_type_select_ab_ff[BIT_OD_A]); // see R1 see R2
        if (tone_pin_enable_ctl_ff[BIT_TONE_EN])
        begin
            nxt_a_o[BIT_TONE_PAD] = tone_in; // see R4
            nxt_a_oe[BIT_TONE_PAD] = 1'b1;
        end
        {nxt_b_oe, nxt_b_o} = drive_pads(data_b_ff, dir_mask_b_ff,
            drive_type_select_ab_ff[BIT_OD_B]); // see R6
        {nxt_e_oe, nxt_e_o} = drive_pads(data_e_ff, {PAD_W{1'b1}},
            pull_and_drive_cd_ef_ff[BIT_OD_E]); // see R15
        {nxt_f_oe, nxt_f_o} = drive_pads(data_f_ff, {PAD_W{1'b1}},
            pull_and_drive_cd_ef_ff[BIT_OD_F]); // see R16
        nxt_pull_c = pull_and_drive_cd_ef_ff[BIT_PULL_C]; // see R7
        nxt_pull_d = pull_and_drive_cd_ef_ff[BIT_PULL_D]; // see R11
        // serial lines float when idle only with the tri-state option
        ser_drive = ~TRISTATE_SERIAL | voice_active; // see R14
        nxt_d_o = RST_NIB;
        nxt_d_oe = RST_NIB;
        if (SHARED_SERIAL)
        begin
            nxt_d_o[BIT_SER_CLK] = ser_clk; // see R13
            nxt_d_oe[BIT_SER_CLK] = ser_drive;
            nxt_d_o[BIT_SER_DATA] = ser_data_out;
            nxt_d_oe[BIT_SER_DATA] = ser_drive & ser_data_drive;
            nxt_d_o[BIT_SER_ADDR] = ser_addr;
            nxt_d_oe[BIT_SER_ADDR] = ser_drive;
        end
        nxt_ser_in = lvl_d[BIT_SER_DATA];
        nxt_event = lvl_c[0]; // see R10
        // any level change on c or d while stopped; held until stop ends
        nxt_wake = armed & (|({lvl_d, lvl_c} ^ prev_ff[POS_LVL_C +: 2*PAD_W]));
        nxt_wake = stop_mode & (wake_ff | nxt_wake); // see R9
    end

    // one flop group for everything; clock enable low freezes it all
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drive_type_select_ab_ff <= RST_NIB;
            dir_mask_a_ff <= RST_NIB; // see R3
            dir_mask_b_ff <= RST_NIB; // see R3
            pull_and_drive_cd_ef_ff <= RST_NIB;
            tone_pin_enable_ctl_ff <= RST_NIB;
            edge_irq_en_low_ff <= RST_NIB;
            edge_irq_en_high_ff <= RST_NIB;
            {data_a_ff, data_b_ff, data_e_ff, data_f_ff} <= '0;
            pend_ff <= RST_PEND;
            prev_ff <= '0;
            warm_ff <= 2'h0;
            prdata_ff <= RST_WORD;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            {a_o_ff, a_oe_ff, b_o_ff, b_oe_ff, d_o_ff, d_oe_ff} <= '0;
            {e_o_ff, e_oe_ff, f_o_ff, f_oe_ff} <= '0;
            {pull_c_ff, pull_d_ff, wake_ff, event_ff, ser_in_ff} <= '0;
        end
        else if (clk_en)
        begin
            drive_type_select_ab_ff <= nxt_drive_type_select_ab;
            dir_mask_a_ff <= nxt_dir_mask_a;
            dir_mask_b_ff <= nxt_dir_mask_b;
            pull_and_drive_cd_ef_ff <= nxt_pull_and_drive_cd_ef;
            tone_pin_enable_ctl_ff <= nxt_tone_pin_enable_ctl;
            edge_irq_en_low_ff <= nxt_edge_irq_en_low;
            edge_irq_en_high_ff <= nxt_edge_irq_en_high;
            {data_a_ff, data_b_ff, data_e_ff, data_f_ff} <= {nxt_data_a, nxt_data_b,
                nxt_data_e, nxt_data_f};
            pend_ff <= nxt_pend;
            prev_ff <= nxt_prev;
            warm_ff <= nxt_warm;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            {a_o_ff, a_oe_ff, b_o_ff, b_oe_ff} <= {nxt_a_o, nxt_a_oe, nxt_b_o, nxt_b_oe};
            {d_o_ff, d_oe_ff, e_o_ff, e_oe_ff} <= {nxt_d_o, nxt_d_oe, nxt_e_o, nxt_e_oe};
            {f_o_ff, f_oe_ff} <= {nxt_f_o, nxt_f_oe};
            {pull_c_ff, pull_d_ff, wake_ff} <= {nxt_pull_c, nxt_pull_d, nxt_wake};
            {event_ff, ser_in_ff} <= {nxt_event, nxt_ser_in};
        end
    end

    // outputs straight from flops, except the irq lines, each an or of its four pending flops
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign port_a_pins_o = a_o_ff;
    assign port_a_pins_oe = a_oe_ff;
    assign port_b_pins_o = b_o_ff;
    assign port_b_pins_oe = b_oe_ff;
    assign wake_input_port_d_o = d_o_ff;
    assign wake_input_port_d_oe = d_oe_ff;
    assign port_e_out_o = e_o_ff;
    assign port_e_out_oe = e_oe_ff;
    assign port_f_out_o = f_o_ff;
    assign port_f_out_oe = f_oe_ff;
    assign pull_en_c = pull_c_ff;
    assign pull_en_d = pull_d_ff;
    assign wake_req = wake_ff;
    assign timer_event_in = event_ff;
    assign ser_data_in = ser_in_ff;
    assign irq_port_a = |pend_ff[POS_PEND_A +: PAD_W]; // see R5
    assign irq_port_c = |pend_ff[POS_PEND_C +: PAD_W];
    assign irq_port_d = |pend_ff[POS_PEND_D +: PAD_W];

    // pending bits that no clear touches this cycle
    logic [3*PAD_W-1:0] pend_keep;
    assign pend_keep = pend_ff & ~pend_clr;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wr_dir_a;
        wr_en && paddr == OFS_DIR_A && clk_en;
    endsequence

    a_dir_a_oe: assert property ( // see R1
        s_wr_dir_a ##1 clk_en && !tone_pin_enable_ctl_ff[BIT_TONE_EN]
        && !drive_type_select_ab_ff[BIT_OD_A] |=> port_a_pins_oe == $past(pwdata[3:0], 2))
        else $error("port a enable does not follow direction mask");
    a_od_a_low: assert property ( // see R2
        drive_type_select_ab_ff[BIT_OD_A] && !tone_pin_enable_ctl_ff[BIT_TONE_EN] && clk_en
        |=> port_a_pins_o == RST_NIB)
        else $error("open drain port a drove high");
    a_tone_on_a3: assert property ( // see R4
        tone_pin_enable_ctl_ff[BIT_TONE_EN] && clk_en
        |=> port_a_pins_oe[BIT_TONE_PAD] && port_a_pins_o[BIT_TONE_PAD] == $past(tone_in))
        else $error("tone not on pad a3");
    a_od_b_mask: assert property ( // see R6
        drive_type_select_ab_ff[BIT_OD_B] && clk_en
        |=> port_b_pins_oe == ($past(dir_mask_b_ff) & ~$past(data_b_ff)))
        else $error("open drain port b enable wrong");
    a_pull_c_d: assert property ( // see R7 see R11
        clk_en |=> {pull_en_d, pull_en_c} == $past(pull_and_drive_cd_ef_ff[3:2]))
        else $error("pull-high enable mismatch");
    a_irq_c_set: assert property ( // see R8 see R18
        clk_en && armed && (chg_c != RST_NIB) |=> irq_port_c)
        else $error("enabled port c change not latched");
    a_pend_hold: assert property ( // see R18
        clk_en && pend_keep != RST_PEND |=> (pend_ff & $past(pend_keep)) == $past(pend_keep))
        else $error("pending request lost without a clear");
    a_wake_c: assert property ( // see R9
        stop_mode && clk_en && armed && (lvl_c != prev_ff[POS_LVL_C +: PAD_W]) |=> wake_req)
        else $error("port c activity did not wake");
    a_event_c0: assert property ( // see R10
        clk_en |=> timer_event_in == $past(lvl_c[0]))
        else $error("timer event input not pad c0");
    a_e_cmos: assert property ( // see R15
        clk_en && !pull_and_drive_cd_ef_ff[BIT_OD_E] |=> port_e_out_oe == 4'hF)
        else $error("cmos port e not fully driven");
    a_ser_float: assert property ( // see R14
        clk_en && TRISTATE_SERIAL && !voice_active |=> wake_input_port_d_oe == RST_NIB)
        else $error("serial lines driven while idle");
endmodule : pad_port_control

/* bench/pad_env_model.sv */
// Purpose: external switches and loads around the pad ports
// Assumes: a switch level stands on every pad nobody drives
// Notes: released open-drain pads show the switch level, so keep it 1 as a pull-high
`timescale 1ns/100ps
module pad_env_model
    import pad_port_pkg::*;
(
    input wire logic [PAD_W-1:0] a_o,
    input wire logic [PAD_W-1:0] a_oe,
    input wire logic [PAD_W-1:0] b_o,
    input wire logic [PAD_W-1:0] b_oe,
    input wire logic [PAD_W-1:0] d_o,
    input wire logic [PAD_W-1:0] d_oe,
    input wire logic [PAD_W-1:0] sw_a,
    input wire logic [PAD_W-1:0] sw_b,
    input wire logic [PAD_W-1:0] sw_d,
    output logic [PAD_W-1:0] a_i,
    output logic [PAD_W-1:0] b_i,
    output logic [PAD_W-1:0] d_i
);
    // wire level: driver wins where enabled, else the switch or pull level
    assign a_i = (a_oe & a_o) | (~a_oe & sw_a);
    assign b_i = (b_oe & b_o) | (~b_oe & sw_b);
    assign d_i = (d_oe & d_o) | (~d_oe & sw_d);
endmodule : pad_env_model

/* bench/pad_port_control_tb.sv */
// Purpose: register-driven checks of pad direction, drive, irq and wake
// Assumes: both serial build options on, clk_en held high
// Notes: pad outputs are checked two edges after a write commits
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("Error %s exp %h got %h", n, e, g); end end
module pad_port_control_tb
    import pad_port_pkg::*;
;
    logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat;
    logic pready, pslverr, perr, tone_in = 0, voice_active = 0, stop_mode = 0;
    logic ser_clk = 0, ser_addr = 0, ser_data_out = 0, ser_data_drive = 0;
    logic [3:0] sw_a = 4'hF, sw_b = 4'hF, sw_c = 4'hF, sw_d = 4'hF;
    logic [3:0] a_i, a_o, a_oe, b_i, b_o, b_oe, d_i, d_o, d_oe, e_o, e_oe, f_o, f_oe;
    logic pull_c, pull_d, wake_req, t_ev, irq_a, irq_c, irq_d, ser_in;
    int errors = 0, checked = 0;
    // 250 MHz clock
    always #2 pclk = ~pclk;
    pad_port_control #(.SHARED_SERIAL(1'b1), .TRISTATE_SERIAL(1'b1)) u_dut (.pclk(pclk),
        .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_a_pins_i(a_i), .port_a_pins_o(a_o),
        .port_a_pins_oe(a_oe), .port_b_pins_i(b_i), .port_b_pins_o(b_o),
        .port_b_pins_oe(b_oe), .wake_input_port_c(sw_c), .pull_en_c(pull_c),
        .wake_input_port_d_i(d_i), .wake_input_port_d_o(d_o), .wake_input_port_d_oe(d_oe),
        .pull_en_d(pull_d), .port_e_out_o(e_o), .port_e_out_oe(e_oe), .port_f_out_o(f_o),
        .port_f_out_oe(f_oe), .tone_in(tone_in), .voice_active(voice_active),
        .ser_clk(ser_clk), .ser_addr(ser_addr), .ser_data_out(ser_data_out),
        .ser_data_drive(ser_data_drive), .ser_data_in(ser_in), .stop_mode(stop_mode),
        .wake_req(wake_req), .timer_event_in(t_ev), .irq_port_a(irq_a), .irq_port_c(irq_c),
        .irq_port_d(irq_d));
    pad_env_model u_env (.a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe), .d_o(d_o),
        .d_oe(d_oe), .sw_a(sw_a), .sw_b(sw_b), .sw_d(sw_d), .a_i(a_i), .b_i(b_i), .d_i(d_i));
    // one apb transfer; request held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            errors++;
        end
        rdat = prdata;
        perr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // write, then let the pad flops follow
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
        repeat (2) @(posedge pclk);
    endtask : wr
    task rdc(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0);
        `CHK($sformatf("reg %h", a), e, rdat)
    endtask : rdc
    task wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_cyc
    task print_verdict;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    // watchdog: the tests need well under 2000 cycles
    initial
    begin
        #20000;
        errors++;
        print_verdict();
    end
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        wait_cyc(2);
        `CHK("a oe", 4'h0, a_oe)
        `CHK("b oe", 4'h0, b_oe)
        rdc(OFS_DIR_A, 0);
        $display("test reset done");
        wr(OFS_DATA_A, 5);
        wr(OFS_DIR_A, 32'h0000_000F);
        `CHK("a cmos", 8'h5F, {a_o, a_oe})
        wr(OFS_DRIVE_AB, 32'h0000_0003);
        `CHK("a od", 8'h0A, {a_o, a_oe})
        wr(OFS_DATA_B, 6);
        wr(OFS_DIR_B, 32'h0000_000C);
        `CHK("b od", 8'h08, {b_o, b_oe})
        wr(OFS_DRIVE_AB, 0);
        `CHK("b cmos", 8'h6C, {b_o, b_oe})
        $display("test port ab done");
        tone_in <= 1;
        wr(OFS_TONE_CTL, 1);
        `CHK("tone pad", 2'h3, {a_o[3], a_oe[3]})
        wr(OFS_TONE_CTL, 0);
        wr(OFS_DATA_E, 9);
        wr(OFS_DATA_F, 3);
        `CHK("e cmos", 8'h9F, {e_o, e_oe})
        wr(OFS_PULL_CDEF, 32'h0000_000F);
        `CHK("e od", 8'h06, {e_o, e_oe})
        `CHK("f od", 8'h0C, {f_o, f_oe})
        `CHK("pulls", 2'h3, {pull_c, pull_d})
        wr(OFS_PULL_CDEF, 32'h0000_0004);
        `CHK("pulls", 2'h2, {pull_c, pull_d})
        `CHK("f cmos", 8'h3F, {f_o, f_oe})
        apb(0, 8'hFC, 0);
        `CHK("unmapped err", 1'b1, perr)
        $display("test outputs done");
        wr(OFS_DIR_A, 0);
        wr(OFS_DIR_B, 0);
        wr(OFS_IRQ_EN_C, 1);
        wr(OFS_IRQ_EN_D, 8);
        wait_cyc(4);
        wr(OFS_IRQ_PEND, 32'h0000_0FFF);
        sw_a <= 4'hD;
        sw_c <= 4'hC;
        sw_d <= 4'h7;
        wait_cyc(5);
        rdc(OFS_IRQ_PEND, 32'h0000_0812);
        `CHK("irqs", 3'h7, {irq_a, irq_c, irq_d})
        `CHK("event", 1'b0, t_ev)
        rdc(OFS_PIN_LVL, 32'h0000_7CFD);
        wr(OFS_IRQ_PEND, 32'h0000_0812);
        `CHK("irqs clr", 3'h0, {irq_a, irq_c, irq_d})
        $display("test irq done");
        stop_mode <= 1;
        wait_cyc(3);
        sw_c <= 4'h8;
        wait_cyc(5);
        `CHK("wake", 1'b1, wake_req)
        stop_mode <= 0;
        wait_cyc(2);
        `CHK("wake end", 1'b0, wake_req)
        $display("test wake done");
        `CHK("ser in idle", 1'b1, ser_in)
        `CHK("d float", 4'h0, d_oe)
        ser_clk <= 1;
        ser_addr <= 1;
        ser_data_out <= 0;
        ser_data_drive <= 1;
        voice_active <= 1;
        wait_cyc(5);
        `CHK("serial d", 8'hAE, {d_o, d_oe})
        `CHK("ser in", 1'b0, ser_in)
        voice_active <= 0;
        wait_cyc(2);
        `CHK("d idle", 4'h0, d_oe)
        $display("test serial done");
        print_verdict();
    end
endmodule : pad_port_control_tb
